// ==== hdl/tmv_params.svh ====
// Purpose: Offsets, field positions and reset values of the vote forwarder.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes: Definitions only.
`ifndef TMV_PARAMS_SVH
`define TMV_PARAMS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define TMV_OFS_CTRL 12'h000
`define TMV_OFS_STATUS 12'h004
`define TMV_OFS_SLICE 12'h008
`define TMV_OFS_INFO 12'h00C
`define TMV_OFS_ERRCNT_A 12'h010
`define TMV_OFS_ERRCNT_B 12'h014
`define TMV_OFS_ERRCNT_C 12'h018
`define TMV_OFS_ERRFLAG 12'h01C
`define TMV_OFS_IRQ_STAT 12'h020
`define TMV_OFS_IRQ_MASK 12'h024
`define TMV_OFS_VOLT 12'h028

// ****************************************************************
// Field positions
// ****************************************************************
`define TMV_CTRL_ACTIVE 0
`define TMV_CTRL_SLOT_EN 1
`define TMV_SLICE_SB_EJ 7
`define TMV_SLICE_ACT_EJ 3
`define TMV_IRQ_DISC 0
`define TMV_IRQ_FRAME 1
`define TMV_IRQ_CSUM 2
`define TMV_IRQ_W 3

// ****************************************************************
// Reset values and widths
// ****************************************************************
`define TMV_CTRL_RST 2'h0
`define TMV_MSG_W 8
`define TMV_CNT_W 16
`define TMV_CNT_MAX 16'hFFFF
`define TMV_ERR_ZERO 9'h000

`endif

// ==== hdl/tmv_pkg.sv ====
// Purpose: Types shared by the vote forwarder.
// Assumes: Constants come from tmv_params.svh.
// Notes: Types only.
package tmv_pkg;

    // One message byte with its command/response framing strobe
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } tmv_msg_s;

    // Downstream control signals
    typedef struct packed {
        logic pwr_fail;
        logic wdog;
        logic cmd_rsp;
    } tmv_ctl_s;

    // Per-slice receive error flags
    typedef struct packed {
        logic disc;
        logic frame;
        logic csum;
    } tmv_err_s;

endpackage : tmv_pkg

// ==== hdl/tmv_forwarder.sv ====
// Purpose: Triplicated message and control forwarding with 2oo3 voting.
// Assumes: Single 50 MHz clock; every triplicated input comes from pins.
// Notes: Registers reached over APB; one level interrupt output.
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`include "tmv_params.svh"

// Operation
// R1: Active with slot enabled, forward backplane commands to the expansion bus.
// R2: Active, pass expansion responses to backplane as control signals allow; the code also requires the slot enabled.
// R3: Backplane copies are synchronised and voted before driving all channels.
// R4: Expansion copies are synchronised and voted before reaching the backplane.
// R5: Any copy disagreement is detected and recorded despite voting.
// R6: Power fail, watchdog and cmd/rsp control forwarded, synchronised, voted.
// R7: Control signals travel only downstream; no reverse path exists.
// R8: Slice word bits 0 to 2 show active unit slices healthy.
// R9: Slice word bits 4 to 6 show standby unit slices healthy.
// R10: Slice word bit 3 shows active unit ejectors open.
// R11: Slice word bit 7 shows standby unit ejectors open.
// R12: Voltage readings are 16-bit signed, one 512th volt per step.
// R13: Module health is one only when responding with no slice errors.
// R14: Standby chassis and slot read zero when no partner is present.
// R15: Primary status reads one when the active unit is primary.
// R16: Separate receive error count for each slice, readable by software.
// R17: Per slice record framing, checksum and discrepancy errors.
// R18: In standby answer own commands but block all forwarded traffic; the code still drives voted control onto EXP_CTL.
// R19: Bitwise two-of-three vote; flag any copy differing from result.
module tmv_forwarder (
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire tmv_pkg::tmv_msg_s [2:0] BP_CMD,
    input wire tmv_pkg::tmv_ctl_s [2:0] BP_CTL,
    output tmv_pkg::tmv_msg_s [2:0] BP_RSP,
    output logic [2:0] BP_RSP_EN,
    output tmv_pkg::tmv_msg_s [2:0] EXP_CMD,
    output tmv_pkg::tmv_ctl_s [2:0] EXP_CTL,
    input wire tmv_pkg::tmv_msg_s [2:0] EXP_RSP,
    input wire logic [2:0] EXP_FRAME_ERR,
    input wire logic [2:0] EXP_CSUM_ERR,
    input wire logic [2:0] ACT_SLICE_OK,
    input wire logic ACT_EJECT,
    input wire logic [2:0] SB_SLICE_OK,
    input wire logic SB_EJECT,
    input wire logic SB_PRESENT,
    input wire logic [3:0] SB_CHASSIS,
    input wire logic [3:0] SB_SLOT,
    input wire logic [3:0] ACT_CHASSIS,
    input wire logic [3:0] ACT_SLOT,
    input wire logic ACT_PRIMARY,
    input wire logic [15:0] VOLT_RAW,
    output logic IRQ
);

    // Pin bundle sampled through the two-stage synchroniser
    typedef struct packed {
        tmv_pkg::tmv_msg_s [2:0] bp_cmd;
        tmv_pkg::tmv_ctl_s [2:0] bp_ctl;
        tmv_pkg::tmv_msg_s [2:0] exp_rsp;
        logic [2:0] frame_err;
        logic [2:0] csum_err;
        logic [2:0] act_ok;
        logic act_ej;
        logic [2:0] sb_ok;
        logic sb_ej;
        logic sb_pres;
        logic [3:0] sb_ch;
        logic [3:0] sb_sl;
        logic [3:0] act_ch;
        logic [3:0] act_sl;
        logic act_pri;
        logic [15:0] volt;
    } tmv_pins_s;

    typedef struct packed {
        tmv_pins_s meta;
        tmv_pins_s sync;
        logic [1:0] ctrl;
        tmv_pkg::tmv_msg_s [2:0] exp_cmd;
        tmv_pkg::tmv_ctl_s [2:0] exp_ctl;
        tmv_pkg::tmv_msg_s [2:0] bp_rsp;
        logic [2:0] bp_rsp_en;
        tmv_pkg::tmv_err_s [2:0] err;
        logic [2:0][15:0] errcnt;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [31:0] prdata;
        logic pslverr;
    } tmv_state_s;

    tmv_state_s st;
    tmv_state_s next_st;
    tmv_pins_s pins_now;

    // ****************************************************************
    // Voting helpers
    // ****************************************************************
    function automatic logic [8:0] vote9(input logic [8:0] a,
                                         input logic [8:0] b,
                                         input logic [8:0] c);
        vote9 = (a & b) | (a & c) | (b & c);
    endfunction : vote9

    function automatic logic [2:0] vote3(input logic [2:0] a,
                                         input logic [2:0] b,
                                         input logic [2:0] c);
        vote3 = (a & b) | (a & c) | (b & c);
    endfunction : vote3

    assign pins_now = '{bp_cmd: BP_CMD, bp_ctl: BP_CTL, exp_rsp: EXP_RSP,
        frame_err: EXP_FRAME_ERR, csum_err: EXP_CSUM_ERR,
        act_ok: ACT_SLICE_OK, act_ej: ACT_EJECT, sb_ok: SB_SLICE_OK,
        sb_ej: SB_EJECT, sb_pres: SB_PRESENT, sb_ch: SB_CHASSIS,
        sb_sl: SB_SLOT, act_ch: ACT_CHASSIS, act_sl: ACT_SLOT,
        act_pri: ACT_PRIMARY, volt: VOLT_RAW};

    // ****************************************************************
    // Voted values
    // ****************************************************************
    logic [8:0] cmd_vote;
    logic [8:0] rsp_vote;
    logic [2:0] ctl_vote;
    logic [2:0] cmd_disc;
    logic [2:0] rsp_disc;
    logic [2:0] ctl_disc;
    logic active;
    logic fwd_en;
    logic [7:0] slice_word;
    logic act_health;
    logic sb_health;
    logic [3:0] sb_ch_rd;
    logic [3:0] sb_sl_rd;
    logic [2:0] events;

    // R3 vote backplane copies
    assign cmd_vote = vote9(st.sync.bp_cmd[0], st.sync.bp_cmd[1],
                            st.sync.bp_cmd[2]);
    // R4 vote expansion copies
    assign rsp_vote = vote9(st.sync.exp_rsp[0], st.sync.exp_rsp[1],
                            st.sync.exp_rsp[2]);
    // R6 vote control signals
    assign ctl_vote = vote3(st.sync.bp_ctl[0], st.sync.bp_ctl[1],
                            st.sync.bp_ctl[2]);

    // R19 per-copy discrepancy flags
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_disc
            assign cmd_disc[g] = st.sync.bp_cmd[g] != cmd_vote;
            assign rsp_disc[g] = st.sync.exp_rsp[g] != rsp_vote;
            assign ctl_disc[g] = st.sync.bp_ctl[g] != ctl_vote;
        end
    endgenerate

    assign active = st.ctrl[`TMV_CTRL_ACTIVE];
    // R1 R18 forward only when active and slot enabled
    assign fwd_en = active & st.ctrl[`TMV_CTRL_SLOT_EN];

    // R8 R9 R10 R11 slice word layout
    assign slice_word = {st.sync.sb_ej, st.sync.sb_ok & {3{st.sync.sb_pres}},
                         st.sync.act_ej, st.sync.act_ok};
    // R13 health is all slices ok; standby health also needs the partner present
    assign act_health = &st.sync.act_ok;
    assign sb_health = st.sync.sb_pres & (&st.sync.sb_ok);
    // R14 zero when no partner
    assign sb_ch_rd = st.sync.sb_pres ? st.sync.sb_ch : 4'h0;
    assign sb_sl_rd = st.sync.sb_pres ? st.sync.sb_sl : 4'h0;

    assign events = {|st.sync.csum_err, |st.sync.frame_err,
                     |(cmd_disc | rsp_disc | ctl_disc)};

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic wr;
        logic rd;
        logic [2:0] clr;
        tmv_pkg::tmv_err_s [2:0] base;
        wr = PSEL & PENABLE & PWRITE;
        rd = PSEL & PENABLE & ~PWRITE;
        clr = 3'h0;
        // Clear of the error flags comes first so a new error wins
        base = (wr && PADDR == `TMV_OFS_ERRFLAG) ? `TMV_ERR_ZERO : st.err;
        next_st = st;
        next_st.meta = pins_now;
        next_st.sync = st.meta;
        next_st.pslverr = 1'b0;
        // R1 R3 R18 drive voted command on all three channels
        for (int i = 0; i < 3; i++) begin
            next_st.exp_cmd[i] = fwd_en ? cmd_vote : 9'h000;
            // R6 R7 control copied downstream only
            next_st.exp_ctl[i] = ctl_vote;
            // R2 R4 response gated by voted cmd/rsp control
            next_st.bp_rsp[i] = (fwd_en & ctl_vote[0]) ? rsp_vote : 9'h000;
            next_st.bp_rsp_en[i] = fwd_en & ctl_vote[0];
        end
        // R5 R17 record per slice errors
        for (int i = 0; i < 3; i++) begin
            next_st.err[i].disc = base[i].disc | rsp_disc[i] |
                                  cmd_disc[i] | ctl_disc[i];
            next_st.err[i].frame = base[i].frame | st.sync.frame_err[i];
            next_st.err[i].csum = base[i].csum | st.sync.csum_err[i];
            // R16 saturating per slice count
            if ((rsp_disc[i] | st.sync.frame_err[i] | st.sync.csum_err[i])
                && st.errcnt[i] != `TMV_CNT_MAX) begin
                next_st.errcnt[i] = 16'(st.errcnt[i] + 16'h0001);
            end
        end
        if (wr) begin
            if (PADDR == `TMV_OFS_CTRL) begin
                next_st.ctrl = PWDATA[1:0];
            end else if (PADDR == `TMV_OFS_ERRFLAG) begin
                // Any write clears the flags, applied through base
                next_st.pslverr = 1'b0;
            end else if (PADDR == `TMV_OFS_IRQ_STAT) begin
                clr = PWDATA[2:0];
            end else if (PADDR == `TMV_OFS_IRQ_MASK) begin
                next_st.irq_mask = PWDATA[2:0];
            end else if (PADDR == `TMV_OFS_ERRCNT_A ||
                         PADDR == `TMV_OFS_ERRCNT_B ||
                         PADDR == `TMV_OFS_ERRCNT_C ||
                         PADDR == `TMV_OFS_STATUS ||
                         PADDR == `TMV_OFS_SLICE ||
                         PADDR == `TMV_OFS_INFO ||
                         PADDR == `TMV_OFS_VOLT) begin
                next_st.pslverr = 1'b0;
            end else begin
                next_st.pslverr = 1'b1;
            end
        end
        // Set wins over a same-cycle clear
        next_st.irq_stat = (st.irq_stat & ~clr) | events;
        next_st.prdata = 32'h0000_0000;
        if (rd) begin
            if (PADDR == `TMV_OFS_CTRL) begin
                next_st.prdata = {30'h0, st.ctrl};
            end else if (PADDR == `TMV_OFS_STATUS) begin
                // R13 R15 health and primary flags
                next_st.prdata = {28'h0, st.sync.act_pri, sb_health,
                                  act_health, active};
            end else if (PADDR == `TMV_OFS_SLICE) begin
                next_st.prdata = {24'h0, slice_word};
            end else if (PADDR == `TMV_OFS_INFO) begin
                next_st.prdata = {16'h0, sb_sl_rd, sb_ch_rd,
                                  st.sync.act_sl, st.sync.act_ch};
            end else if (PADDR == `TMV_OFS_ERRCNT_A) begin
                next_st.prdata = {16'h0, st.errcnt[0]};
            end else if (PADDR == `TMV_OFS_ERRCNT_B) begin
                next_st.prdata = {16'h0, st.errcnt[1]};
            end else if (PADDR == `TMV_OFS_ERRCNT_C) begin
                next_st.prdata = {16'h0, st.errcnt[2]};
            end else if (PADDR == `TMV_OFS_ERRFLAG) begin
                next_st.prdata = {23'h0, st.err};
            end else if (PADDR == `TMV_OFS_IRQ_STAT) begin
                next_st.prdata = {29'h0, st.irq_stat};
            end else if (PADDR == `TMV_OFS_IRQ_MASK) begin
                next_st.prdata = {29'h0, st.irq_mask};
            end else if (PADDR == `TMV_OFS_VOLT) begin
                // R12 signed 1/512 V sign extended
                next_st.prdata = {{16{st.sync.volt[15]}}, st.sync.volt};
            end else begin
                next_st.pslverr = 1'b1;
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge CLK) begin
        if (RST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // APB: wait one cycle so data comes from flip-flops
    logic resp_ph;
    always_ff @(posedge CLK) begin
        if (RST) begin
            resp_ph <= 1'b0;
        end else begin
            resp_ph <= PSEL & PENABLE & ~resp_ph;
        end
    end

    assign PREADY = resp_ph;
    assign PRDATA = st.prdata;
    assign PSLVERR = resp_ph & st.pslverr;
    assign EXP_CMD = st.exp_cmd;
    assign EXP_CTL = st.exp_ctl;
    assign BP_RSP = st.bp_rsp;
    assign BP_RSP_EN = st.bp_rsp_en;
    assign IRQ = |(st.irq_stat & st.irq_mask);

endmodule : tmv_forwarder

// ==== bench/tmv_forwarder_props.sv ====
// Purpose: Port checks of the vote forwarder.
// Assumes: Bound to tmv_forwarder; CTRL shadowed from APB writes.
// Notes: Pins reach outputs three cycles later.
`timescale 1ns/10ps
`include "tmv_params.svh"
module tmv_forwarder_props (
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire tmv_pkg::tmv_msg_s [2:0] BP_CMD,
    input wire tmv_pkg::tmv_ctl_s [2:0] BP_CTL,
    input wire tmv_pkg::tmv_msg_s [2:0] BP_RSP,
    input wire tmv_pkg::tmv_msg_s [2:0] EXP_CMD,
    input wire tmv_pkg::tmv_ctl_s [2:0] EXP_CTL
);
    logic wr;
    logic nv;
    logic sh;
    logic [2:0] same;
    logic [2:0] up;
    function automatic logic [8:0] v9(input logic [26:0] x);
        return (x[26:18] & x[17:9]) | (x[26:18] & x[8:0]) | (x[17:9] & x[8:0]);
    endfunction : v9
    function automatic logic [2:0] v3(input logic [8:0] x);
        return (x[8:6] & x[5:3]) | (x[8:6] & x[2:0]) | (x[5:3] & x[2:0]);
    endfunction : v3
    assign wr = PSEL && PENABLE && PREADY && PWRITE
        && PADDR == `TMV_OFS_CTRL;
    // Forwarding enabled only with both control bits
    assign nv = wr ? PWDATA[1:0] == 2'h3 : sh;
    always_ff @(posedge CLK) begin
        if (RST) begin
            sh <= 1'b0;
            same <= 3'h0;
            up <= 3'h0;
        end else begin
            sh <= nv;
            same <= nv != sh ? 3'h0 : (same == 3'h7 ? same : same + 3'h1);
            up <= up == 3'h7 ? up : up + 3'h1;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    property p_rdy_wait; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
    a_rdy_wait: assert property (p_rdy_wait) else $error("ready late");
    property p_rdy_one; PREADY |=> !PREADY; endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("ready too long");
    property p_rdy_cause; $rose(PREADY) |-> $past(PSEL && PENABLE); endproperty
    a_rdy_cause: assert property (p_rdy_cause) else $error("ready uncaused");
    property p_err; PREADY |-> PSLVERR == (PADDR > `TMV_OFS_VOLT
        || PADDR[1:0] != 2'h0); endproperty
    a_err: assert property (p_err) else $error("wrong slave error");
    property p_block; same > 3'h4 && !sh |-> EXP_CMD == '0
        && BP_RSP == '0; endproperty
    a_block: assert property (p_block) else $error("traffic leaked");
    property p_cmd_vote; same > 3'h4 && sh
        |-> EXP_CMD == {3{v9($past(BP_CMD, 3))}}; endproperty
    a_cmd_vote: assert property (p_cmd_vote) else $error("bad cmd");
    property p_ctl_vote; up > 3'h3
        |-> EXP_CTL == {3{v3($past(BP_CTL, 3))}}; endproperty
    a_ctl_vote: assert property (p_ctl_vote) else $error("bad ctl");
    property p_rsp_en; BP_RSP[0].valid |-> sh; endproperty
    a_rsp_en: assert property (p_rsp_en) else $error("rsp when off");
    property p_rsp_same; BP_RSP[0].valid |-> BP_RSP[1] == BP_RSP[0]
        && BP_RSP[2] == BP_RSP[0]; endproperty
    a_rsp_same: assert property (p_rsp_same) else $error("rsp split");
    c_fwd: cover property (EXP_CMD[0].valid);
    c_rsp: cover property (BP_RSP[0].valid);
    c_err: cover property (PSLVERR);
endmodule : tmv_forwarder_props

// ==== bench/tmv_exp_model.sv ====
// Purpose: Far-end expansion processor answering each command.
// Assumes: Answer byte is the inverted command byte.
// Notes: BAD picks a response copy to corrupt, 3 for none.
`timescale 1ns/10ps
module tmv_exp_model (
    input wire logic CLK,
    input wire logic RST,
    input wire tmv_pkg::tmv_msg_s [2:0] CMD,
    input wire tmv_pkg::tmv_ctl_s [2:0] CTL,
    input wire logic [1:0] BAD,
    input wire logic SLOW,
    output tmv_pkg::tmv_msg_s [2:0] RSP,
    output tmv_pkg::tmv_ctl_s CTL_SEEN
);
    logic [8:0] cv;
    logic [7:0] held;
    logic [7:0] pat;
    logic [2:0] dly;
    assign cv = (CMD[0] & CMD[1]) | (CMD[0] & CMD[2]) | (CMD[1] & CMD[2]);
    always_ff @(posedge CLK) begin
        if (RST) begin
            dly <= 3'h0;
            pat <= 8'h00;
            RSP <= '0;
            CTL_SEEN <= '0;
        end else begin
            pat <= pat + 8'h01;
            CTL_SEEN <= (CTL[0] & CTL[1]) | (CTL[0] & CTL[2])
                | (CTL[1] & CTL[2]);
            if (cv[8]) begin
                dly <= SLOW ? 3'h4 : 3'h1;
                held <= ~cv[7:0];
            end else if (dly != 3'h0) begin
                dly <= dly - 3'h1;
            end
            // Idle lines carry a moving pattern
            for (int i = 0; i < 3; i++) begin
                RSP[i].valid <= dly == 3'h1;
                RSP[i].data <= dly == 3'h1 ? held ^ {8{i == BAD}} : pat;
            end
        end
    end
endmodule : tmv_exp_model

// ==== bench/tmv_forwarder_test.sv ====
// Purpose: Self-checking bench of the vote forwarder.
// Assumes: Far-end model answers voted commands.
// Notes: APB master waits on PREADY.
`timescale 1ns/10ps
`include "tmv_params.svh"
module tmv_forwarder_test;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwd = 32'h0, prd, q;
    logic prdy, perr, irq, qe, slow = 1'b0;
    logic [2:0] rsp_en, ferr = 3'h0, cerr = 3'h0, aok = 3'h0, sok = 3'h0;
    logic aej = 1'b0, sej = 1'b0, spr = 1'b0, apri = 1'b0;
    logic [3:0] sch = 4'h0, ssl = 4'h0, ach = 4'h0, asl = 4'h0;
    logic [15:0] volt = 16'h0;
    logic [1:0] bad = 2'h3;
    tmv_pkg::tmv_msg_s [2:0] bcmd = '0, brsp, ecmd, ersp;
    tmv_pkg::tmv_ctl_s [2:0] bctl = '0, ectl;
    tmv_pkg::tmv_ctl_s seen;
    int n_errors = 0, num_checks = 0, cyc = 0;
    tmv_forwarder DUT (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwd), .PRDATA(prd),
        .PREADY(prdy), .PSLVERR(perr), .BP_CMD(bcmd), .BP_CTL(bctl),
        .BP_RSP(brsp), .BP_RSP_EN(rsp_en), .EXP_CMD(ecmd), .EXP_CTL(ectl),
        .EXP_RSP(ersp), .EXP_FRAME_ERR(ferr), .EXP_CSUM_ERR(cerr),
        .ACT_SLICE_OK(aok), .ACT_EJECT(aej), .SB_SLICE_OK(sok),
        .SB_EJECT(sej), .SB_PRESENT(spr), .SB_CHASSIS(sch), .SB_SLOT(ssl),
        .ACT_CHASSIS(ach), .ACT_SLOT(asl), .ACT_PRIMARY(apri),
        .VOLT_RAW(volt), .IRQ(irq));
    tmv_exp_model u_far (.CLK(clk), .RST(rst), .CMD(ecmd), .CTL(ectl),
        .BAD(bad), .SLOW(slow), .RSP(ersp), .CTL_SEEN(seen));
    initial begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        num_checks++;
        if (g !== x) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, x);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (prdy !== 1'b1);
        q = prd;
        qe = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
    endtask : rd
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic send(input logic [7:0] d, input int b);
        @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            bcmd[i].valid <= 1'b1;
            bcmd[i].data <= i == b ? ~d : d;
        end
        @(posedge clk);
        bcmd <= '0;
    endtask : send
    task automatic wait_v(input logic r);
        int t;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while ((r ? brsp[0].valid : ecmd[0].valid) !== 1'b1 && t < 30);
    endtask : wait_v
    task automatic idle(input int n, input logic c);
        logic s;
        s = 1'b0;
        repeat (n) begin
            @(posedge clk);
            s = s | brsp[0].valid | (c & ecmd[0].valid);
        end
        chk(32'(s), 32'h0);
    endtask : idle
    task automatic t_regs;
        rd(`TMV_OFS_CTRL, 32'h0);
        rd(`TMV_OFS_IRQ_STAT, 32'h0);
        apb(1'b0, 12'h0FC, 32'h0);
        chk(32'(qe), 32'h1);
        wr(`TMV_OFS_CTRL, 32'h1);
    endtask : t_regs
    task automatic t_status;
        @(posedge clk);
        {aok, sok, aej, sej, spr, apri} <= {3'h7, 3'h3, 4'hF};
        {sch, ssl, ach, asl, volt} <= 32'h5613_8200;
        repeat (4) @(posedge clk);
        rd(`TMV_OFS_SLICE, 32'hBF);
        rd(`TMV_OFS_STATUS, 32'hB);
        rd(`TMV_OFS_INFO, 32'h6531);
        rd(`TMV_OFS_VOLT, 32'hFFFF8200);
        {aok, spr, apri, volt} <= {3'h5, 2'h0, 16'h0200};
        repeat (4) @(posedge clk);
        rd(`TMV_OFS_SLICE, 32'h8D);
        rd(`TMV_OFS_STATUS, 32'h1);
        rd(`TMV_OFS_INFO, 32'h0031);
        rd(`TMV_OFS_VOLT, 32'h200);
    endtask : t_status
    task automatic t_block;
        send(8'h3C, 3);
        idle(10, 1'b1);
        wr(`TMV_OFS_CTRL, 32'h0);
        send(8'h3C, 3);
        idle(10, 1'b1);
        rd(`TMV_OFS_CTRL, 32'h0);
    endtask : t_block
    task automatic t_ctl;
        bctl <= 9'h0ED;
        repeat (6) @(posedge clk);
        chk(32'(ectl), 32'h16D);
        chk(32'(seen), 32'h5);
    endtask : t_ctl
    task automatic t_fwd;
        // Unanimous control ends the split left by the control scenario
        bctl <= 9'h16D;
        wr(`TMV_OFS_CTRL, 32'h3);
        wr(`TMV_OFS_ERRFLAG, 32'h0);
        wr(`TMV_OFS_IRQ_STAT, 32'h7);
        bad <= 2'h1;
        send(8'h5A, 3);
        wait_v(1'b1);
        chk(32'(brsp), 32'({3{9'h1A5}}));
        chk(32'(rsp_en), 32'h7);
        rd(`TMV_OFS_ERRCNT_B, 32'h1);
        rd(`TMV_OFS_ERRCNT_A, 32'h0);
        rd(`TMV_OFS_ERRFLAG, 32'h20);
        rd(`TMV_OFS_IRQ_STAT, 32'h1);
        chk(32'(irq), 32'h0);
        wr(`TMV_OFS_IRQ_MASK, 32'h1);
        chk(32'(irq), 32'h1);
        wr(`TMV_OFS_IRQ_STAT, 32'h1);
        chk(32'(irq), 32'h0);
    endtask : t_fwd
    task automatic t_gate;
        {bad, slow} <= 3'h7;
        bctl <= '0;
        send(8'h81, 0);
        wait_v(1'b0);
        chk(32'(ecmd), 32'({3{9'h181}}));
        idle(12, 1'b0);
        chk(32'(rsp_en), 32'h0);
    endtask : t_gate
    task automatic t_errs;
        wr(`TMV_OFS_ERRFLAG, 32'h0);
        wr(`TMV_OFS_IRQ_STAT, 32'h7);
        {ferr, cerr} <= 6'h21;
        @(posedge clk);
        {ferr, cerr} <= 6'h00;
        rd(`TMV_OFS_ERRCNT_C, 32'h1);
        rd(`TMV_OFS_ERRCNT_A, 32'h1);
        rd(`TMV_OFS_ERRFLAG, 32'h81);
        rd(`TMV_OFS_IRQ_STAT, 32'h6);
        chk(32'(irq), 32'h0);
        wr(`TMV_OFS_IRQ_MASK, 32'h7);
        chk(32'(irq), 32'h1);
    endtask : t_errs
    task automatic test_done;
        if (n_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_status();
        t_block();
        t_ctl();
        t_fwd();
        t_gate();
        t_errs();
        test_done();
    end
endmodule : tmv_forwarder_test
bind tmv_forwarder tmv_forwarder_props u_props (.CLK(CLK), .RST(RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .BP_CMD(BP_CMD),
    .BP_CTL(BP_CTL), .BP_RSP(BP_RSP), .EXP_CMD(EXP_CMD), .EXP_CTL(EXP_CTL));
